/* File: logic/sfq_globals.sv */
module sfq_globals #(
    parameter int unsigned MS_CYC = sfq_pkg::MS_CYCLES
) (
    input  wire logic                  I_MCLK,
    input  wire logic                  I_RESET,
    input  wire logic [7:0]            I_REG_ADDR,
    input  wire logic                  I_REG_WR,
    input  wire logic                  I_REG_RD,
    input  wire logic [7:0]            I_REG_WDATA,
    output logic      [7:0]            O_REG_RDATA,
    output logic                       O_REG_RVALID,
    input  wire logic                  I_FRAME_VALID,
    input  wire logic                  I_UNKNOWN_IPMC,
    input  wire logic [7:0]            I_TOS,
    input  wire logic [2:0]            I_SRC_PORT,
    input  wire logic [2:0]            I_EGR_PORT,
    input  wire logic [4:0]            I_CTRL0_INS,
    input  wire logic [4:0][4:0]       I_CTRL8_INS,
    output logic                       O_RES_VALID,
    output sfq_pkg::sfq_res_s          O_RES,
    output logic                       O_RATE_TICK,
    output logic                       O_EGRESS_QUEUE_MODE,
    output logic                       O_SELF_FILTER_EN
);
    import sfq_pkg::*;

    sfq_cfg_s    cfg_q;
    sfq_res_s    res_d;
    sfq_res_s    res_q;
    logic        res_vld_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic [7:0]  rd_mux;
    logic        wr_uipm;
    logic        wr_rate;
    logic        wr_map;
    logic [31:0] pre_q;
    logic [8:0]  ms_q;
    logic [8:0]  per_ms;
    logic        ms_tick;
    logic        per_done;
    logic        tick_q;

    ////////////////////////////////////////////////////////////////////////
    // register access

    assign wr_uipm = I_REG_WR & (I_REG_ADDR == OFS_UIPM_CTRL);
    assign wr_rate = I_REG_WR & (I_REG_ADDR == OFS_RATE_TAG);
    assign wr_map  = I_REG_WR & (I_REG_ADDR == OFS_CP_MAP0);

    // reserved bits are built as constant zero, so writes cannot stick
    assign rd_mux =
        (I_REG_ADDR == OFS_UIPM_CTRL) ?
            {1'b0, cfg_q.self_filt, cfg_q.uipm_en, cfg_q.uipm_map} :
        (I_REG_ADDR == OFS_RATE_TAG) ?
            {2'h0, cfg_q.rate_per, cfg_q.egr_queue,
             cfg_q.pvid_sel, 2'h0} :
        (I_REG_ADDR == OFS_CP_MAP0) ? cfg_q.cp_map0 : 8'h00;

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            cfg_q.self_filt <= 1'b0;
            cfg_q.uipm_en   <= 1'b0;
            cfg_q.uipm_map  <= RST_UIPM_MAP;
            cfg_q.rate_per  <= RST_RATE_PER;
            cfg_q.egr_queue <= 1'b0;
            cfg_q.pvid_sel  <= 1'b0;
            cfg_q.cp_map0   <= RST_CP_MAP0;
        end else begin
            if (wr_uipm) begin
                cfg_q.self_filt <= I_REG_WDATA[POS_SELF_FILT];
                cfg_q.uipm_en   <= I_REG_WDATA[POS_UIPM_EN];
                cfg_q.uipm_map  <= I_REG_WDATA[POS_UIPM_MAP +: 5];
            end
            if (wr_rate) begin
                cfg_q.rate_per  <= I_REG_WDATA[POS_RATE_PER +: 2];
                cfg_q.egr_queue <= I_REG_WDATA[POS_EGR_QUEUE];
                cfg_q.pvid_sel  <= I_REG_WDATA[POS_PVID_SEL];
            end
            if (wr_map) begin
                cfg_q.cp_map0   <= I_REG_WDATA;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= I_REG_RD;
            if (I_REG_RD) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign O_REG_RDATA         = rdata_q;
    assign O_REG_RVALID        = rvalid_q;
    assign O_EGRESS_QUEUE_MODE = cfg_q.egr_queue;
    assign O_SELF_FILTER_EN    = cfg_q.self_filt;

    ////////////////////////////////////////////////////////////////////////
    // per-frame decisions

    sfq_lookup u_lookup (
        .i_unknown_ipmc (I_UNKNOWN_IPMC),
        .i_tos          (I_TOS),
        .i_src_port     (I_SRC_PORT),
        .i_egr_port     (I_EGR_PORT),
        .i_ctrl0_ins    (I_CTRL0_INS),
        .i_ctrl8_ins    (I_CTRL8_INS),
        .i_cfg          (cfg_q),
        .o_fwd          (),
        .o_res          (res_d)
    );

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            res_q     <= '0;
            res_vld_q <= 1'b0;
        end else begin
            res_vld_q <= I_FRAME_VALID;
            if (I_FRAME_VALID) begin
                res_q <= res_d;
            end
        end
    end

    assign O_RES       = res_q;
    assign O_RES_VALID = res_vld_q;

    ////////////////////////////////////////////////////////////////////////
    // ingress rate period tick

    // 1x both mean 256 ms, so both fall through to the last branch
    assign per_ms = (cfg_q.rate_per == PER_16MS) ? 9'(PER_16_MS) :
                    (cfg_q.rate_per == PER_64MS) ? 9'(PER_64_MS) :
                                                   9'(PER_256_MS);
    assign ms_tick  = (pre_q == 32'(MS_CYC - 1));
    // >= so a shorter period chosen mid-count ends at the next millisecond tick
    assign per_done = ms_tick & ((ms_q + 9'h001) >= per_ms);

    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            pre_q  <= 32'h0000_0000;
            ms_q   <= 9'h000;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= ms_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
            tick_q <= per_done;
            if (per_done) begin
                ms_q <= 9'h000;
            end else if (ms_tick) begin
                ms_q <= ms_q + 9'h001;
            end
        end
    end

    assign O_RATE_TICK = tick_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    fwd_map_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_FRAME_VALID && I_UNKNOWN_IPMC && cfg_q.uipm_en
        |=> O_RES.fwd_mask == $past(cfg_q.uipm_map))
        else $error("unknown ip multicast mask differs from map");

    fwd_off_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_FRAME_VALID && !cfg_q.uipm_en
        |=> O_RES.fwd_mask == 5'h00 && !O_RES.drop)
        else $error("special forwarding active while disabled");

    drop_zero_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_FRAME_VALID && I_UNKNOWN_IPMC && cfg_q.uipm_en
        |=> O_RES.drop == ($past(cfg_q.uipm_map) == 5'h00))
        else $error("drop does not follow empty map");

    reset_val_a: assert property (@(posedge I_MCLK)
        $past(I_RESET) |-> cfg_q.rate_per == RST_RATE_PER &&
        cfg_q.uipm_map == RST_UIPM_MAP && cfg_q.cp_map0 == RST_CP_MAP0)
        else $error("wrong value after reset");

    period_len_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        ms_tick && ms_q == 9'(PER_16_MS - 1) && cfg_q.rate_per == PER_16MS
        |=> O_RATE_TICK ##1 !O_RATE_TICK)
        else $error("16 ms period tick missing");

    egr_mode_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        wr_rate |=> O_EGRESS_QUEUE_MODE == $past(I_REG_WDATA[POS_EGR_QUEUE]))
        else $error("egress mode not taken from write");

    ins_per_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_FRAME_VALID && cfg_q.pvid_sel && I_SRC_PORT < 3'h5 &&
        I_EGR_PORT < 3'h5
        |=> O_RES.ins_tag == $past(I_CTRL8_INS[I_EGR_PORT][I_SRC_PORT]))
        else $error("per source insertion wrong");

    ins_glob_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_FRAME_VALID && !cfg_q.pvid_sel && I_SRC_PORT < 3'h5
        |=> O_RES.ins_tag == $past(I_CTRL0_INS[I_SRC_PORT]))
        else $error("global insertion wrong");

    prio_cp3_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_FRAME_VALID && I_TOS[7:2] == 6'h03
        |=> O_RES.prio_hit && O_RES.prio == $past(cfg_q.cp_map0[7:6]))
        else $error("code point 3 priority wrong");

    prio_cp0_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_FRAME_VALID && I_TOS[7:2] == 6'h00
        |=> O_RES.prio == $past(cfg_q.cp_map0[1:0]))
        else $error("code point 0 priority wrong");

    map_rw_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        wr_map ##1 (I_REG_RD && I_REG_ADDR == OFS_CP_MAP0 && !I_REG_WR)
        |=> O_REG_RDATA == $past(I_REG_WDATA, 2))
        else $error("map register readback wrong");

    resv_zero_a: assert property (@(posedge I_MCLK) disable iff (I_RESET)
        I_REG_RD && I_REG_ADDR == OFS_RATE_TAG
        |=> O_REG_RDATA[7:6] == 2'h0 && O_REG_RDATA[1:0] == 2'h0)
        else $error("reserved bits read non-zero");
endmodule

/* File: logic/sfq_pkg.sv */
package sfq_pkg;

    localparam int unsigned NUM_PORTS = 5;

    // register offsets
    localparam logic [7:0] OFS_UIPM_CTRL = 8'h86;
    localparam logic [7:0] OFS_RATE_TAG  = 8'h87;
    localparam logic [7:0] OFS_CP_MAP0   = 8'h90;

    // field positions in global_ctrl_unknown_ip_mcast
    localparam int unsigned POS_SELF_FILT = 6;
    localparam int unsigned POS_UIPM_EN   = 5;
    localparam int unsigned POS_UIPM_MAP  = 0;
    // field positions in global_ctrl_rate_tag_select
    localparam int unsigned POS_RATE_PER  = 4;
    localparam int unsigned POS_EGR_QUEUE = 3;
    localparam int unsigned POS_PVID_SEL  = 2;

    // reset values
    localparam logic [4:0] RST_UIPM_MAP = 5'h00;
    localparam logic [1:0] RST_RATE_PER = 2'h1;
    localparam logic [7:0] RST_CP_MAP0  = 8'h00;

    // rate period encodings and lengths
    localparam logic [1:0] PER_16MS   = 2'h0;
    localparam logic [1:0] PER_64MS   = 2'h1;
    localparam int unsigned PER_16_MS  = 16;
    localparam int unsigned PER_64_MS  = 64;
    localparam int unsigned PER_256_MS = 256;

    // timing: one millisecond at the core clock
    localparam int unsigned CLK_HZ    = 25_000_000;
    localparam int unsigned MS_TIME   = 1;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * MS_TIME;

    typedef struct packed {
        logic       self_filt;
        logic       uipm_en;
        logic [4:0] uipm_map;
        logic [1:0] rate_per;
        logic       egr_queue;
        logic       pvid_sel;
        logic [7:0] cp_map0;
    } sfq_cfg_s;

    typedef struct packed {
        logic       prio_hit;
        logic [1:0] prio;
        logic [4:0] fwd_mask;
        logic       drop;
        logic       ins_tag;
    } sfq_res_s;

endpackage

/* File: logic/sfq_lookup.sv */
module sfq_lookup (
    input  wire logic                  i_unknown_ipmc,
    input  wire logic [7:0]            i_tos,
    input  wire logic [2:0]            i_src_port,
    input  wire logic [2:0]            i_egr_port,
    input  wire logic [4:0]            i_ctrl0_ins,
    input  wire logic [4:0][4:0]       i_ctrl8_ins,
    input  wire sfq_pkg::sfq_cfg_s     i_cfg,
    output logic                       o_fwd,
    output sfq_pkg::sfq_res_s          o_res
);
    import sfq_pkg::*;

    logic [5:0]       code;
    logic [3:0][1:0]  cp_field;
    logic             src_ok;
    logic             egr_ok;
    logic             ins_per_src;
    logic             ins_global;

    // codes 0..3 live here; the rest of the table sits elsewhere
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cp
            assign cp_field[g] = i_cfg.cp_map0[2*g +: 2];
        end
    endgenerate

    assign code           = i_tos[7:2];
    assign o_res.prio_hit = (code < 6'h04);
    assign o_res.prio     = o_res.prio_hit ? cp_field[code[1:0]] : 2'h0;

    assign o_fwd          = i_unknown_ipmc & i_cfg.uipm_en;
    assign o_res.fwd_mask = o_fwd ? i_cfg.uipm_map : 5'h00;
    assign o_res.drop     = o_fwd & (i_cfg.uipm_map == 5'h00);

    assign src_ok      = (i_src_port < 3'h5);
    assign egr_ok      = (i_egr_port < 3'h5);
    assign ins_per_src = src_ok & egr_ok &
                         i_ctrl8_ins[i_egr_port][i_src_port];
    assign ins_global  = src_ok & i_ctrl0_ins[i_src_port];
    assign o_res.ins_tag = i_cfg.pvid_sel ? ins_per_src : ins_global;
endmodule

/* File: verif/test_switch_forwarding_qos_globals.sv */
module test_switch_forwarding_qos_globals;
    timeunit 1ns;
    timeprecision 1ns;
    import sfq_pkg::*;

    // short prescaler keeps the 256 ms period at 1024 cycles
    localparam int unsigned MSC = 4;

    logic                clk;
    logic                rst;
    logic                wr;
    logic                rd;
    logic                fv;
    logic                unk;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic [7:0]          tos;
    logic [2:0]          src;
    logic [2:0]          egr;
    logic [4:0]          c0;
    logic [4:0][4:0]     c8;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                resv;
    logic                tick;
    logic                eqm;
    logic                sfe;
    sfq_res_s            res;
    int                  mismatches = 0;
    int                  n_tests = 0;

    sfq_globals #(.MS_CYC(MSC)) DUT (
        .I_MCLK(clk), .I_RESET(rst), .I_REG_ADDR(addr), .I_REG_WR(wr),
        .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rvalid), .I_FRAME_VALID(fv), .I_UNKNOWN_IPMC(unk),
        .I_TOS(tos), .I_SRC_PORT(src), .I_EGR_PORT(egr), .I_CTRL0_INS(c0),
        .I_CTRL8_INS(c8), .O_RES_VALID(resv), .O_RES(res),
        .O_RATE_TICK(tick), .O_EGRESS_QUEUE_MODE(eqm),
        .O_SELF_FILTER_EN(sfe)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk("rvalid", 16'h0001, {15'h0, rvalid});
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask

    // one frame, result checked after the answer edge has settled
    task automatic frame(input logic u, input logic [7:0] t,
                         input logic [2:0] s, input logic [2:0] e);
        @(posedge clk);
        fv  <= 1'b1;
        unk <= u;
        tos <= t;
        src <= s;
        egr <= e;
        @(posedge clk);
        fv  <= 1'b0;
        #1;
        chk("res_valid", 16'h0001, {15'h0, resv});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset_and_reserved();
        reg_rd(OFS_UIPM_CTRL, 8'h00);
        reg_rd(OFS_RATE_TAG, 8'h10);
        reg_rd(OFS_CP_MAP0, 8'h00);
        reg_rd(8'h88, 8'h00);
        reg_wr(OFS_RATE_TAG, 8'hFF);
        reg_rd(OFS_RATE_TAG, 8'h3C);
        chk("egress_queue_mode", 16'h0001, {15'h0, eqm});
        reg_wr(OFS_UIPM_CTRL, 8'hFF);
        reg_rd(OFS_UIPM_CTRL, 8'h7F);
        chk("self_filter_en", 16'h0001, {15'h0, sfe});
        reg_wr(OFS_RATE_TAG, 8'h10);
        chk("egress_queue_mode", 16'h0000, {15'h0, eqm});
        reg_wr(8'h88, 8'hA5);
        reg_rd(8'h88, 8'h00);
    endtask

    task automatic test_unknown_mcast();
        logic [4:0] maps [4] = '{5'h00, 5'h01, 5'h03, 5'h1F};
        logic [4:0] m;
        for (int i = 0; i < 8; i++) begin
            m = maps[i % 4];
            reg_wr(OFS_UIPM_CTRL, {2'h0, 1'(i / 4), m});
            frame(1'b1, 8'h00, 3'h0, 3'h0);
            chk("fwd_mask", {11'h0, (i >= 4) ? m : 5'h00},
                {11'h0, res.fwd_mask});
            chk("drop", {15'h0, i == 4}, {15'h0, res.drop});
        end
        frame(1'b0, 8'h00, 3'h0, 3'h0);
        chk("fwd_mask_known", 16'h0000, {11'h0, res.fwd_mask});
    endtask

    task automatic test_codepoint();
        // write then read on the very next cycle
        @(posedge clk);
        addr  <= OFS_CP_MAP0;
        wdata <= 8'h1B;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        #1;
        chk("rdata_b2b", 16'h001B, {8'h00, rdata});
        // distinct value per field catches a swapped slice
        reg_wr(OFS_CP_MAP0, 8'hE4);
        reg_rd(OFS_CP_MAP0, 8'hE4);
        for (int cp = 0; cp < 4; cp++) begin
            frame(1'b0, 8'((cp << 2) | 3), 3'h0, 3'h0);
            chk("prio", 16'(cp), {14'h0, res.prio});
            chk("prio_hit", 16'h0001, {15'h0, res.prio_hit});
        end
        frame(1'b0, 8'h10, 3'h0, 3'h0);
        chk("prio_hit_far", 16'h0000, {15'h0, res.prio_hit});
    endtask

    task automatic test_tag_insert();
        c0 <= 5'h16;
        c8 <= {5{5'h09}};
        for (int sel = 0; sel < 2; sel++) begin
            reg_wr(OFS_RATE_TAG, sel ? 8'h14 : 8'h10);
            for (int s = 0; s < 6; s++) begin
                frame(1'b0, 8'h00, 3'(s), 3'h2);
                chk("ins_tag", (s > 4) ? 16'h0 :
                    16'(sel ? 5'h09 >> s & 1 : 5'h16 >> s & 1),
                    {15'h0, res.ins_tag});
            end
        end
    endtask

    task automatic wait_tick();
        for (int i = 0; i < 2000 && tick !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic test_rate_period();
        int n;
        for (int p = 0; p < 4; p++) begin
            reg_wr(OFS_RATE_TAG, 8'(p << 4));
            wait_tick();
            @(posedge clk);
            #1;
            wait_tick();
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (tick !== 1'b1 && n < 2000);
            chk("tick_interval",
                16'(MSC * (p == 0 ? 16 : p == 1 ? 64 : 256)),
                16'(n));
        end
    endtask

    // reset in mid-run must bring back defaults over written values
    task automatic test_mid_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reg_rd(OFS_RATE_TAG, 8'h10);
        reg_rd(OFS_UIPM_CTRL, 8'h00);
        reg_rd(OFS_CP_MAP0, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst   <= 1'b1;
        wr    <= 1'b0;
        rd    <= 1'b0;
        fv    <= 1'b0;
        unk   <= 1'b0;
        addr  <= 8'h00;
        wdata <= 8'h00;
        tos   <= 8'h00;
        src   <= 3'h0;
        egr   <= 3'h0;
        c0    <= 5'h00;
        c8    <= '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        test_reset_and_reserved();
        test_unknown_mcast();
        test_codepoint();
        test_tag_insert();
        test_rate_period();
        test_mid_reset();
        finish_test();
    end

    // all scenarios need well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end
endmodule
